// ---- inc/lane_ovr_pkg.sv ----
package lane_ovr_pkg;
    localparam int ADDR_W     = 8;
    localparam int DATA_W     = 16;
    localparam int ID_W       = 5;
    localparam int CHK_W      = 8;
    localparam int MF_W       = 5;
    localparam int NUM_LANES  = 4;
    localparam int MF_LEN_DEF = 32;

    localparam logic [ADDR_W-1:0] OFS_LINK_SEL  = 8'h03;
    localparam logic [ADDR_W-1:0] OFS_MF_PRESET = 8'h78;
    localparam logic [ADDR_W-1:0] OFS_LANE_EN   = 8'h86;
    localparam logic [ADDR_W-1:0] OFS_CHK56     = 8'h87;
    localparam logic [ADDR_W-1:0] OFS_CHK78     = 8'h88;
    localparam logic [ADDR_W-1:0] OFS_ID56      = 8'h89;
    localparam logic [ADDR_W-1:0] OFS_ID78      = 8'h8a;

    localparam int LINK_SEL_BIT  = 5;
    localparam int MF_FORCE_BIT  = 15;
    localparam int MF_PRESET_LSB = 10;
    localparam int LANE_EN_LSB   = 8;
    localparam int EN_W          = 8;
    localparam int HI_LSB        = 8;
    localparam int LO_LSB        = 0;

    localparam logic [DATA_W-1:0] RD_ZERO  = 16'h0000;
    localparam logic [MF_W-1:0]   MF_ZERO  = 5'h00;
    localparam logic [MF_W-1:0]   MF_ONE   = 5'h01;
    localparam logic [ID_W-1:0]   ID_ZERO  = 5'h00;
    localparam logic [CHK_W-1:0]  CHK_ZERO = 8'h00;
    localparam logic [EN_W-1:0]   EN_ZERO  = 8'h00;

    // Index 0 is lane 5, index 3 is lane 8.
    localparam logic [NUM_LANES-1:0][ID_W-1:0] DEFAULT_ID = {5'h08, 5'h07, 5'h06, 5'h05};

    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic             id_en;
        logic             chk_en;
        logic [ID_W-1:0]  id;
        logic [CHK_W-1:0] chk;
    } lane_cfg_t;

    typedef struct packed {
        logic [ID_W-1:0]  id;
        logic [CHK_W-1:0] chk;
        logic             chk_forced;
    } lane_out_t;
endpackage

// ---- src/lane_param_select.sv ----
`timescale 1ns/100ps
module lane_param_select #(
    parameter logic [lane_ovr_pkg::ID_W-1:0] DEF_ID = lane_ovr_pkg::ID_ZERO
) (
    input  wire logic                              mclk,
    input  wire logic                              rst,
    input  wire logic                              ce,
    input  wire lane_ovr_pkg::lane_cfg_t           cfg,
    input  wire logic [lane_ovr_pkg::CHK_W-1:0]    computed_chk,
    output lane_ovr_pkg::lane_out_t                lane_out
);
    import lane_ovr_pkg::*;

    lane_out_t out_d;
    lane_out_t out_q;

    // Picks the programmed or default identifier and checksum for one lane.
    always_comb begin
        out_d.id         = cfg.id_en ? cfg.id : DEF_ID;            // R4 R5 R6 R7
        out_d.chk        = cfg.chk_en ? cfg.chk : computed_chk;    // R8 R9
        out_d.chk_forced = cfg.chk_en;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            out_q <= '{id: ID_ZERO, chk: CHK_ZERO, chk_forced: 1'b0};
        end else if (ce) begin
            out_q <= out_d;
        end
    end

    assign lane_out = out_q;
endmodule // lane_param_select

// ---- src/lane_ovr_regs.sv ----
`timescale 1ns/100ps
// Operation
// R1 - A restart loads the multiframe counter from the preset when force is set, else from zero.
// R2 - The preset is a five-bit field in bits 14-10 of the multiframe preset register.
// R3 - Upper-lane override enables act only while the write-select bit (reg 3 bit 5) is 1.
// R4 - Lane 5 sends identifier 00101 unless enabled, then the value in reg 137 bits 12-8.
// R5 - Lane 6 sends identifier 00110 unless enabled, then the value in reg 137 bits 4-0.
// R6 - Lane 7 sends identifier 00111 unless enabled, then the value in reg 138 bits 12-8.
// R7 - Lane 8 sends identifier 01000 unless enabled, then the value in reg 138 bits 4-0.
// R8 - Lane 5 sends the computed checksum unless enabled, then reg 135 bits 15-8.
// R9 - Lanes 6 to 8 send the computed checksum unless enabled, then their programmed field.
// R10 - Reg 137 holds the lane 5 identifier in bits 12-8 and lane 6 in bits 4-0.
// R11 - Reg 135 holds the lane 5 checksum in bits 15-8 and lane 6 in bits 7-0.
// R12 - Reg 136 holds the lane 7 checksum in bits 15-8 and lane 8 in bits 7-0.
// R13 - Software writes zero to every reserved bit of these registers.
// R14 - Lane 7 and 8 checksum overrides come from the reg 136 fields.
module lane_ovr_regs #(
    parameter int MF_LEN = lane_ovr_pkg::MF_LEN_DEF
) (
    input  wire logic                                                mclk,
    input  wire logic                                                rst,
    input  wire logic                                                ce,
    input  wire lane_ovr_pkg::reg_req_t                              req,
    output logic [lane_ovr_pkg::DATA_W-1:0]                          rd_data,
    input  wire logic                                                frame_tick,
    input  wire logic                                                mf_restart,
    input  wire logic [lane_ovr_pkg::NUM_LANES-1:0][lane_ovr_pkg::CHK_W-1:0] computed_chk,
    output lane_ovr_pkg::lane_out_t [lane_ovr_pkg::NUM_LANES-1:0]    lane_out,
    output logic [lane_ovr_pkg::MF_W-1:0]                            mf_count,
    output logic                                                     mf_wrap
);
    import lane_ovr_pkg::*;

    if (MF_LEN < 2 || MF_LEN > (1 << MF_W)) begin : g_bad_mf_len
        $error("MF_LEN out of range");
    end
    if (NUM_LANES != 4 || EN_W != 2 * NUM_LANES) begin : g_bad_lanes
        $error("lane count does not match the enable register");
    end

    localparam logic [MF_W-1:0] MF_LAST = MF_W'(MF_LEN - 1);

    function automatic logic hit(input reg_req_t r, input logic [ADDR_W-1:0] ofs);
        hit = (r.addr == ofs);
    endfunction

    function automatic logic [DATA_W-1:0] pack_pair(input logic [CHK_W-1:0] hi,
                                                   input logic [CHK_W-1:0] lo);
        pack_pair = {hi, lo};
    endfunction

    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        is_mapped = (a == OFS_LINK_SEL) || (a == OFS_MF_PRESET) || (a == OFS_LANE_EN)
                    || (a == OFS_CHK56) || (a == OFS_CHK78) || (a == OFS_ID56)
                    || (a == OFS_ID78);
    endfunction

    // Register state.
    logic                                link_sel_q,  link_sel_d;
    logic                                mf_force_q,  mf_force_d;
    logic [MF_W-1:0]                     mf_preset_q, mf_preset_d;
    logic [EN_W-1:0]                     lane_en_q,   lane_en_d;
    logic [1:0][1:0][CHK_W-1:0]          chk_q,       chk_d;
    logic [1:0][1:0][ID_W-1:0]           id_q,        id_d;
    logic [DATA_W-1:0]                   rd_data_q,   rd_data_d;

    logic                                wr_en;
    logic                                rd_en;

    assign wr_en = ce && req.wr;
    assign rd_en = ce && req.rd;

    // Write decode; reserved bits are not stored.
    always_comb begin
        link_sel_d  = link_sel_q;
        mf_force_d  = mf_force_q;
        mf_preset_d = mf_preset_q;
        lane_en_d   = lane_en_q;
        chk_d       = chk_q;
        id_d        = id_q;
        if (wr_en) begin
            if (hit(req, OFS_LINK_SEL)) begin
                link_sel_d = req.wdata[LINK_SEL_BIT];
            end
            if (hit(req, OFS_MF_PRESET)) begin
                mf_force_d  = req.wdata[MF_FORCE_BIT];
                mf_preset_d = req.wdata[MF_PRESET_LSB +: MF_W];           // R2
            end
            if (hit(req, OFS_LANE_EN)) begin
                lane_en_d = req.wdata[LANE_EN_LSB +: EN_W];
            end
            if (hit(req, OFS_CHK56)) begin
                chk_d[0][0] = req.wdata[HI_LSB +: CHK_W];                 // R11
                chk_d[0][1] = req.wdata[LO_LSB +: CHK_W];                 // R11
            end
            if (hit(req, OFS_CHK78)) begin
                chk_d[1][0] = req.wdata[HI_LSB +: CHK_W];                 // R12
                chk_d[1][1] = req.wdata[LO_LSB +: CHK_W];                 // R12
            end
            if (hit(req, OFS_ID56)) begin
                id_d[0][0] = req.wdata[HI_LSB +: ID_W];                   // R10
                id_d[0][1] = req.wdata[LO_LSB +: ID_W];                   // R10
            end
            if (hit(req, OFS_ID78)) begin
                id_d[1][0] = req.wdata[HI_LSB +: ID_W];
                id_d[1][1] = req.wdata[LO_LSB +: ID_W];
            end
        end
    end

    // Read mux; unmapped addresses and reserved bits read zero.
    always_comb begin
        rd_data_d = rd_data_q;
        if (rd_en) begin
            rd_data_d = RD_ZERO;
            case (req.addr)
                OFS_LINK_SEL:  rd_data_d[LINK_SEL_BIT] = link_sel_q;
                OFS_MF_PRESET: begin
                    rd_data_d[MF_FORCE_BIT]             = mf_force_q;
                    rd_data_d[MF_PRESET_LSB +: MF_W]    = mf_preset_q;
                end
                OFS_LANE_EN:   rd_data_d[LANE_EN_LSB +: EN_W] = lane_en_q;
                OFS_CHK56:     rd_data_d = pack_pair(chk_q[0][0], chk_q[0][1]);
                OFS_CHK78:     rd_data_d = pack_pair(chk_q[1][0], chk_q[1][1]);
                OFS_ID56:      rd_data_d = pack_pair(CHK_W'(id_q[0][0]), CHK_W'(id_q[0][1]));
                OFS_ID78:      rd_data_d = pack_pair(CHK_W'(id_q[1][0]), CHK_W'(id_q[1][1]));
                default:       rd_data_d = RD_ZERO;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            link_sel_q  <= 1'b0;
            mf_force_q  <= 1'b0;
            mf_preset_q <= MF_ZERO;
            lane_en_q   <= EN_ZERO;
            chk_q       <= '0;
            id_q        <= '0;
            rd_data_q   <= RD_ZERO;
        end else if (ce) begin
            link_sel_q  <= link_sel_d;
            mf_force_q  <= mf_force_d;
            mf_preset_q <= mf_preset_d;
            lane_en_q   <= lane_en_d;
            chk_q       <= chk_d;
            id_q        <= id_d;
            rd_data_q   <= rd_data_d;
        end
    end

    assign rd_data = rd_data_q;

    // Local multiframe counter.
    logic [MF_W-1:0] mf_cnt_q, mf_cnt_d;
    logic            mf_wrap_q, mf_wrap_d;

    always_comb begin
        mf_cnt_d  = mf_cnt_q;
        mf_wrap_d = 1'b0;
        if (mf_restart) begin
            mf_cnt_d = mf_force_q ? mf_preset_q : MF_ZERO;               // R1
        end else if (frame_tick) begin
            if (mf_cnt_q == MF_LAST) begin
                mf_cnt_d  = MF_ZERO;
                mf_wrap_d = 1'b1;
            end else begin
                mf_cnt_d = mf_cnt_q + MF_ONE;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            mf_cnt_q  <= MF_ZERO;
            mf_wrap_q <= 1'b0;
        end else if (ce) begin
            mf_cnt_q  <= mf_cnt_d;
            mf_wrap_q <= mf_wrap_d;
        end
    end

    assign mf_count = mf_cnt_q;
    assign mf_wrap  = mf_wrap_q;

    // Per-lane override selection.
    logic      [NUM_LANES-1:0] eff_id_en;
    logic      [NUM_LANES-1:0] eff_chk_en;
    lane_cfg_t [NUM_LANES-1:0] cfg;

    for (genvar k = 0; k < NUM_LANES; k++) begin : g_lane
        assign eff_id_en[k]  = link_sel_q && lane_en_q[EN_W-1-k];          // R3
        assign eff_chk_en[k] = link_sel_q && lane_en_q[NUM_LANES-1-k];     // R3
        assign cfg[k].id_en  = eff_id_en[k];
        assign cfg[k].chk_en = eff_chk_en[k];
        assign cfg[k].id     = id_q[k/2][k%2];                              // R4 R5 R6 R7
        assign cfg[k].chk    = chk_q[k/2][k%2];                             // R8 R9 R14

        lane_param_select #(
            .DEF_ID (DEFAULT_ID[k])
        ) u_sel (
            .mclk         (mclk),
            .rst          (rst),
            .ce           (ce),
            .cfg          (cfg[k]),
            .computed_chk (computed_chk[k]),
            .lane_out     (lane_out[k])
        );

        a_lane_ident: assert property (@(posedge mclk) disable iff (rst) // R4 R5 R6 R7
            ce |=> lane_out[k].id == ($past(eff_id_en[k]) ? $past(cfg[k].id)
                                                          : DEFAULT_ID[k]))
            else $error("lane identifier mismatch");

        a_lane_chk: assert property (@(posedge mclk) disable iff (rst) // R8 R9 R14
            ce |=> lane_out[k].chk == ($past(eff_chk_en[k]) ? $past(chk_q[k/2][k%2])
                                                            : $past(computed_chk[k])))
            else $error("lane checksum mismatch");
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    a_mf_force_load: assert property ( // R1
        ce && mf_restart && mf_force_q |=> mf_count == $past(mf_preset_q))
        else $error("forced multiframe load wrong");

    a_mf_default_load: assert property ( // R1
        ce && mf_restart && !mf_force_q |=> mf_count == MF_ZERO)
        else $error("default multiframe load wrong");

    a_preset_field: assert property ( // R2
        wr_en && hit(req, OFS_MF_PRESET)
        |=> mf_preset_q == $past(req.wdata[MF_PRESET_LSB +: MF_W]))
        else $error("preset field not stored");

    a_select_gates: assert property ( // R3
        ce && !link_sel_q |=> !lane_out[0].chk_forced && !lane_out[3].chk_forced
                              && lane_out[1].id == DEFAULT_ID[1])
        else $error("override active without write select");

    a_id_storage: assert property ( // R10
        wr_en && hit(req, OFS_ID56) ##1 ce && req.rd && hit(req, OFS_ID56)
        |=> rd_data[HI_LSB +: ID_W] == $past(req.wdata[HI_LSB +: ID_W], 2)
            && rd_data[LO_LSB +: ID_W] == $past(req.wdata[LO_LSB +: ID_W], 2))
        else $error("lane 5/6 identifier readback wrong");

    a_chk56_storage: assert property ( // R11
        wr_en && hit(req, OFS_CHK56) |=> {chk_q[0][0], chk_q[0][1]} == $past(req.wdata))
        else $error("lane 5/6 checksum not stored");

    a_chk78_read: assert property ( // R12
        rd_en && hit(req, OFS_CHK78) |=> rd_data == $past({chk_q[1][0], chk_q[1][1]}))
        else $error("lane 7/8 checksum readback wrong");

    a_mf_wrap: assert property (
        ce && !mf_restart && frame_tick && mf_count == MF_LAST
        |=> mf_wrap && mf_count == MF_ZERO)
        else $error("multiframe wrap wrong");

    // Storage, readback and hold checks on the register side.
    a_link_sel_store: assert property ( // R3
        wr_en && hit(req, OFS_LINK_SEL) |=> link_sel_q == $past(req.wdata[LINK_SEL_BIT]))
        else $error("write select not stored");

    a_enable_store: assert property ( // R3
        wr_en && hit(req, OFS_LANE_EN)
        |=> lane_en_q == $past(req.wdata[LANE_EN_LSB +: EN_W]))
        else $error("lane enables not stored");

    a_lane_en_read: assert property ( // R3
        rd_en && hit(req, OFS_LANE_EN) |=> rd_data == {$past(lane_en_q), EN_ZERO})
        else $error("lane enable readback wrong");

    a_chk56_read: assert property ( // R11
        rd_en && hit(req, OFS_CHK56) |=> rd_data == $past({chk_q[0][0], chk_q[0][1]}))
        else $error("lane 5/6 checksum readback wrong");

    a_chk78_storage: assert property ( // R12
        wr_en && hit(req, OFS_CHK78) |=> {chk_q[1][0], chk_q[1][1]} == $past(req.wdata))
        else $error("lane 7/8 checksum not stored");

    a_id78_storage: assert property ( // R6 R7
        wr_en && hit(req, OFS_ID78)
        |=> id_q[1][0] == $past(req.wdata[HI_LSB +: ID_W])
            && id_q[1][1] == $past(req.wdata[LO_LSB +: ID_W]))
        else $error("lane 7/8 identifier not stored");

    a_unmapped_read: assert property (
        rd_en && !is_mapped(req.addr) |=> rd_data == RD_ZERO)
        else $error("unmapped read not zero");

    a_read_hold: assert property (
        ce && !req.rd |=> $stable(rd_data))
        else $error("read data changed without a read");

    a_mf_hold: assert property (
        ce && !mf_restart && !frame_tick |=> $stable(mf_count))
        else $error("multiframe counter moved without cause");

    a_wrap_single: assert property (
        ce && mf_wrap |=> !mf_wrap)
        else $error("multiframe wrap longer than one cycle");

    a_ce_freeze: assert property (
        !ce |=> $stable(mf_count) && $stable(rd_data) && $stable(lane_out)
                && $stable(mf_wrap))
        else $error("state changed while clock enable low");

    c_force_load: cover property (ce && mf_restart && mf_force_q);
    c_ident_override: cover property (ce && eff_id_en[2]);
    c_chk_override: cover property (ce && eff_chk_en[3]);
    c_read_back: cover property (rd_en && hit(req, OFS_LANE_EN));
    c_wrap_pulse: cover property (ce && mf_wrap);
endmodule // lane_ovr_regs

// ---- testbench/lane_rx_model.sv ----
`timescale 1ns/100ps
module lane_rx_model (
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic       mf_wrap,
    output logic [7:0]      wrap_cnt
);
    import lane_ovr_pkg::*;
    logic [7:0] wrap_cnt_d;

    // The receiver counts the multiframe boundary pulses on mf_wrap.
    always_comb begin
        wrap_cnt_d = mf_wrap ? wrap_cnt + 8'h01 : wrap_cnt;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            wrap_cnt <= 8'h00;
        end else begin
            wrap_cnt <= wrap_cnt_d;
        end
    end
endmodule // lane_rx_model

// ---- testbench/jesd_lane_param_override_regs_test.sv ----
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin error_cnt++; \
    $display("BAD %s expected %h seen %h", nm, (ex), (got)); end end
module jesd_lane_param_override_regs_test;
    import lane_ovr_pkg::*;
    localparam int LEN = 4;
    logic                            mclk, rst, ce, frame_tick, mf_restart, mf_wrap, sel;
    reg_req_t                        req;
    logic [DATA_W-1:0]               rd_data;
    logic [NUM_LANES-1:0][CHK_W-1:0] cchk, ovr_chk;
    logic [NUM_LANES-1:0][ID_W-1:0]  ovr_id;
    lane_out_t [NUM_LANES-1:0]       lane_out;
    logic [MF_W-1:0]                 mf_count;
    logic [7:0]                      wrap_cnt;
    logic [ADDR_W-1:0]               offs [8];
    int                              error_cnt, comparisons;

    lane_ovr_regs #(.MF_LEN(LEN)) dut (.mclk(mclk), .rst(rst), .ce(ce), .req(req),
        .rd_data(rd_data), .frame_tick(frame_tick), .mf_restart(mf_restart),
        .computed_chk(cchk), .lane_out(lane_out), .mf_count(mf_count), .mf_wrap(mf_wrap));
    lane_rx_model rx (.mclk(mclk), .rst(rst), .mf_wrap(mf_wrap), .wrap_cnt(wrap_cnt));

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge mclk);
        req <= '0;
        @(posedge mclk);
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] ex);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(posedge mclk);
        req <= '0;
        #1;
        `CHK("rd_data", ex, rd_data)
        @(posedge mclk);
    endtask

    // Expected lane fields follow from the write-select and the enable byte.
    task automatic lanes(input logic [7:0] en);
        logic ie;
        logic ke;
        repeat (3) @(posedge mclk);
        #1;
        for (int l = 0; l < NUM_LANES; l++) begin
            ie = sel & en[7-l];
            ke = sel & en[3-l];
            `CHK("lane id", ie ? ovr_id[l] : ID_W'(5 + l), lane_out[l].id)
            `CHK("lane chk", ke ? ovr_chk[l] : cchk[l], lane_out[l].chk)
            `CHK("lane forced", ke, lane_out[l].chk_forced)
        end
        @(posedge mclk);
    endtask

    task automatic mf(input logic rs, input logic ft, input logic [MF_W-1:0] cnt,
                      input logic wrp);
        mf_restart <= rs;
        frame_tick <= ft;
        @(posedge mclk);
        mf_restart <= 1'b0;
        frame_tick <= 1'b0;
        #1;
        `CHK("mf_count", cnt, mf_count)
        `CHK("mf_wrap", wrp, mf_wrap)
        @(posedge mclk);
    endtask

    task automatic complete_run();
        $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    initial begin
        repeat (3000) @(posedge mclk);
        error_cnt++;
        complete_run();
    end

    initial begin
        rst = 1'b1;
        ce = 1'b1;
        frame_tick = 1'b0;
        mf_restart = 1'b0;
        req = '0;
        sel = 1'b0;
        error_cnt = 0;
        comparisons = 0;
        cchk = {8'h44, 8'h33, 8'h22, 8'h11};
        ovr_id = {5'h03, 5'h15, 5'h0d, 5'h1e};
        ovr_chk = {8'h34, 8'h12, 8'hcd, 8'hab};
        offs = '{OFS_LINK_SEL, OFS_MF_PRESET, OFS_LANE_EN, OFS_CHK56, OFS_CHK78,
                 OFS_ID56, OFS_ID78, 8'h10};
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        foreach (offs[i]) rd(offs[i], 16'h0000);
        lanes(8'h00);
        req <= '{wr: 1'b1, rd: 1'b0, addr: OFS_ID56, wdata: 16'h1f1f};
        @(posedge mclk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: OFS_ID56, wdata: 16'h0000};
        @(posedge mclk);
        req <= '0;
        #1;
        `CHK("rd_data", 16'h1f1f, rd_data)
        @(posedge mclk);
        wr(OFS_ID56, 16'h1e0d);
        wr(OFS_ID78, 16'h1503);
        wr(OFS_CHK56, 16'habcd);
        wr(OFS_CHK78, 16'h1234);
        rd(OFS_ID56, 16'h1e0d);
        rd(OFS_ID78, 16'h1503);
        rd(OFS_CHK56, 16'habcd);
        rd(OFS_CHK78, 16'h1234);
        wr(OFS_LANE_EN, 16'hff00);
        rd(OFS_LANE_EN, 16'hff00);
        lanes(8'hff);
        wr(OFS_LINK_SEL, 16'h0020);
        sel = 1'b1;
        rd(OFS_LINK_SEL, 16'h0020);
        lanes(8'hff);
        for (int i = 0; i < 8; i++) begin
            wr(OFS_LANE_EN, {8'(8'h80 >> i), 8'h00});
            lanes(8'(8'h80 >> i));
        end
        wr(OFS_LANE_EN, 16'hff00);
        wr(OFS_LINK_SEL, 16'h0000);
        sel = 1'b0;
        cchk <= {8'h5a, 8'ha5, 8'h0f, 8'hf0};
        lanes(8'hff);
        rd(OFS_LANE_EN, 16'hff00);
        ce <= 1'b0;
        wr(OFS_CHK56, 16'h5555);
        ce <= 1'b1;
        rd(OFS_CHK56, 16'habcd);
        wr(OFS_MF_PRESET, 16'hfc00);
        rd(OFS_MF_PRESET, 16'hfc00);
        wr(OFS_MF_PRESET, 16'h8c00);
        mf(1'b1, 1'b0, 5'h03, 1'b0);
        mf(1'b0, 1'b1, 5'h00, 1'b1);
        mf(1'b0, 1'b1, 5'h01, 1'b0);
        mf(1'b1, 1'b1, 5'h03, 1'b0);
        wr(OFS_MF_PRESET, 16'h0c00);
        mf(1'b1, 1'b0, 5'h00, 1'b0);
        #1;
        `CHK("wrap_cnt", 8'h01, wrap_cnt)
        @(posedge mclk);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        #1;
        `CHK("reset mf_count", MF_ZERO, mf_count)
        `CHK("reset rd_data", RD_ZERO, rd_data)
        `CHK("reset lane id", ID_ZERO, lane_out[0].id)
        @(posedge mclk);
        rst <= 1'b0;
        rd(OFS_CHK56, 16'h0000);
        lanes(8'h00);
        complete_run();
    end
endmodule // jesd_lane_param_override_regs_test
